//--- design/hsr_pkg.sv
// Purpose : shared constants and types of the sensor register bank
// Assumes : one 25 MHz clock, synchronous active-high reset
// Notes   : byte-level frame port; bus framing lives outside the bank
package hsr_pkg;

    // ==================================================================
    // pointer values
    localparam logic [7:0]  PTR_TEMP    = 8'h00;
    localparam logic [7:0]  PTR_HUM     = 8'h01;
    localparam logic [7:0]  PTR_CFG     = 8'h02;
    localparam logic [7:0]  PTR_SN_HI   = 8'hFB;
    localparam logic [7:0]  PTR_SN_MID  = 8'hFC;
    localparam logic [7:0]  PTR_SN_LO   = 8'hFD;
    localparam logic [7:0]  PTR_RESET   = 8'h00;

    // ==================================================================
    // reset values and config field positions
    localparam logic [15:0] CFG_RESET    = 16'h1000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int          CFG_RST_BIT  = 15;
    localparam int          CFG_HEAT_BIT = 13;
    localparam int          CFG_MODE_BIT = 12;
    localparam int          CFG_SUP_BIT  = 11;
    localparam int          CFG_TEMP_RESOLUTION_SEL_BIT = 10;
    localparam int          CFG_RH_RESOLUTION_SEL_LO  = 8;
    localparam logic [1:0]  RH_RESOLUTION_SEL_14      = 2'h0;
    localparam logic [1:0]  RH_RESOLUTION_SEL_11      = 2'h1;
    localparam int          CODE_W       = 14;

    // ==================================================================
    // conversion timing
    localparam int CLK_NS     = 40;
    localparam int CONV_14_NS = 8000;
    localparam int CONV_11_NS = 4000;
    localparam int CONV_8_NS  = 2000;
    localparam int CONV_14_CYC = (CONV_14_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_11_CYC = (CONV_11_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_8_CYC  = (CONV_8_NS + CLK_NS - 1) / CLK_NS;

    // ==================================================================
    // types
    typedef enum logic [3:0] {
        HSR_IDLE = 4'h1,
        HSR_PTR  = 4'h2,
        HSR_WR   = 4'h4,
        HSR_RD   = 4'h8
    } hsr_fst_e;

    typedef enum logic [2:0] {
        HSR_M_IDLE = 3'h1,
        HSR_M_TEMP = 3'h2,
        HSR_M_HUM  = 3'h4
    } hsr_mst_e;

    typedef struct packed {
        logic       start;
        logic       rnw;
        logic       wr_valid;
        logic [7:0] wr_byte;
        logic       rd_req;
        logic       stop;
    } hsr_link_s;

    typedef struct packed {
        logic       ack_valid;
        logic       ack;
        logic       rd_valid;
        logic [7:0] rd_byte;
    } hsr_resp_s;

    typedef struct packed {
        logic       heat;
        logic       mode;
        logic       temp_resolution_sel;
        logic [1:0] rh_resolution_sel;
    } hsr_cfg_s;

endpackage

//--- design/hsr_meas.sv
// Purpose : measurement sequencer, paces conversions by resolution
// Assumes : codes from the converter are valid when a load pulse fires
// Notes   : a new start aborts and restarts any running conversion
`timescale 1ns/1ns
module hsr_meas (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // control
    input  wire logic                        clr_i,
    input  wire logic                        start_i,
    input  wire logic                        hum_only_i,
    input  wire logic                        both_i,
    input  wire logic                        temp_resolution_sel_i,
    input  wire logic [1:0]                  rh_resolution_sel_i,
    // status
    output logic                             busy_o,
    output logic                             temp_ld_o,
    output logic                             rh_ld_o,
    output logic                             done_o
);
    typedef struct packed {
        hsr_pkg::hsr_mst_e st;
        logic [15:0]       cnt;
        logic              temp_ld;
        logic              rh_ld;
        logic              done;
    } hsr_meas_s;

    localparam logic [15:0] C14 = 16'(hsr_pkg::CONV_14_CYC);
    localparam logic [15:0] C11 = 16'(hsr_pkg::CONV_11_CYC);
    localparam logic [15:0] C8  = 16'(hsr_pkg::CONV_8_CYC);

    hsr_meas_s   s_r;
    hsr_meas_s   s_nxt;
    logic [15:0] tcyc;
    logic [15:0] hcyc;

    // ==================================================================
    // conversion time follows resolution; stored width never does
    assign tcyc = temp_resolution_sel_i ? C11 : C14;
    assign hcyc = (rh_resolution_sel_i == hsr_pkg::RH_RESOLUTION_SEL_14) ? C14 :
                  (rh_resolution_sel_i == hsr_pkg::RH_RESOLUTION_SEL_11) ? C11 : C8;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.temp_ld = 1'b0;
        s_nxt.rh_ld   = 1'b0;
        s_nxt.done    = 1'b0;
        if (clr_i) begin
            s_nxt.st  = hsr_pkg::HSR_M_IDLE;
            s_nxt.cnt = 16'h0000;
        end else if (start_i) begin
            if (hum_only_i) begin
                s_nxt.st  = hsr_pkg::HSR_M_HUM;
                s_nxt.cnt = hcyc;
            end else begin
                s_nxt.st  = hsr_pkg::HSR_M_TEMP;
                s_nxt.cnt = tcyc;
            end
        end else begin
            unique case (s_r.st)
                hsr_pkg::HSR_M_IDLE: begin
                end
                hsr_pkg::HSR_M_TEMP: begin
                    if (s_r.cnt == 16'h0001) begin
                        s_nxt.temp_ld = 1'b1;
                        if (both_i) begin
                            s_nxt.st  = hsr_pkg::HSR_M_HUM;
                            s_nxt.cnt = hcyc;
                        end else begin
                            s_nxt.st   = hsr_pkg::HSR_M_IDLE;
                            s_nxt.done = 1'b1;
                        end
                    end else begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                    end
                end
                hsr_pkg::HSR_M_HUM: begin
                    if (s_r.cnt == 16'h0001) begin
                        s_nxt.rh_ld = 1'b1;
                        s_nxt.done  = 1'b1;
                        s_nxt.st    = hsr_pkg::HSR_M_IDLE;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r    <= '0;
            s_r.st <= hsr_pkg::HSR_M_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o    = (s_r.st != hsr_pkg::HSR_M_IDLE);
    assign temp_ld_o = s_r.temp_ld;
    assign rh_ld_o   = s_r.rh_ld;
    assign done_o    = s_r.done;

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_seq_temp_first;
        start_i && !clr_i && !hum_only_i |=>
            s_r.st == hsr_pkg::HSR_M_TEMP;
    endproperty
    a_seq_temp_first: assert property (p_seq_temp_first)
        else $error("sequence did not begin with temperature");

    property p_seq_then_hum;
        s_r.st == hsr_pkg::HSR_M_TEMP && s_r.cnt == 16'h0001 && both_i
            && !start_i && !clr_i |=> s_r.st == hsr_pkg::HSR_M_HUM;
    endproperty
    a_seq_then_hum: assert property (p_seq_then_hum)
        else $error("humidity did not follow temperature");

    property p_temp_resolution_sel_time;
        start_i && !clr_i && !hum_only_i |=>
            s_r.cnt == (temp_resolution_sel_i ? C11 : C14);
    endproperty
    a_temp_resolution_sel_time: assert property (p_temp_resolution_sel_time)
        else $error("temperature conversion time wrong");

    property p_rh_resolution_sel_time;
        start_i && !clr_i && hum_only_i && rh_resolution_sel_i == 2'h2 |=>
            s_r.cnt == C8;
    endproperty
    a_rh_resolution_sel_time: assert property (p_rh_resolution_sel_time)
        else $error("humidity 8 bit conversion time wrong");

    c_both_done: cover property (s_r.rh_ld && both_i);
endmodule

//--- design/hsr_regbank.sv
// Purpose : pointer-addressed register bank of a humidity sensor
// Assumes : the serial front end delivers whole bytes and frame marks
// Notes   : results always hold 14 bits, resolution only sets the time
//
// Operation
// - write frame's first byte loads pointer
// - pointer resets to temperature result
// - temperature result read-only, low bits zero
// - humidity result read-only, low bits zero
// - results always stored as 14 bits
// - reset values: config 1000, results zero
// - config bit 15 soft reset, self-clears
// - bit 12 sequences temperature then humidity
// - bit 11 reports low supply
// - read-only 40-bit unique part number
// - pointer FB returns number bits 39-24
// - pointer FC returns number bits 23-8
// - pointer FD returns low byte, rest zero
// - bit 10 selects temperature resolution
// - bits 9-8 select humidity resolution
// - pointer write 00 or 01 triggers measurement
// - nack data to read-only, unused pointers
`timescale 1ns/1ns
module hsr_regbank #(
    parameter logic [39:0] UNIQUE_PART_NUMBER = 40'h0123456789
) (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // byte-level frame port
    input  wire hsr_pkg::hsr_link_s           link_i,
    output hsr_pkg::hsr_resp_s                resp_o,
    // converter and supply monitor
    input  wire logic [hsr_pkg::CODE_W-1:0]   temp_code_i,
    input  wire logic [hsr_pkg::CODE_W-1:0]   rh_code_i,
    input  wire logic                         supply_low_i,
    // status pins
    output logic                              conversion_done_n_o,
    output logic                              heater_en_o
);
    typedef struct packed {
        hsr_pkg::hsr_fst_e st;
        logic [7:0]        ptr;
        logic              hi;
        logic [7:0]        wbuf;
        hsr_pkg::hsr_cfg_s cfg;
        logic [15:0]       temp;
        logic [15:0]       rh;
        logic              drdy_n;
        logic [1:0]        sup_sync;
        logic              sup;
        hsr_pkg::hsr_resp_s resp;
        logic              trig;
        logic              clr;
    } hsr_bank_s;

    hsr_bank_s   s_r;
    hsr_bank_s   s_nxt;
    logic        busy;
    logic        temp_ld;
    logic        rh_ld;
    logic        done;
    logic [15:0] rword;
    logic [15:0] cfg_word;
    logic [15:0] wword;
    logic        ptr_known;
    logic        ptr_result;

    // ==================================================================
    // measurement sequencer
    hsr_meas u_meas (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .clr_i      (s_r.clr),
        .start_i    (s_r.trig),
        .hum_only_i (s_r.ptr == hsr_pkg::PTR_HUM),
        .both_i     (s_r.cfg.mode),
        .temp_resolution_sel_i     (s_r.cfg.temp_resolution_sel),
        .rh_resolution_sel_i     (s_r.cfg.rh_resolution_sel),
        .busy_o     (busy),
        .temp_ld_o  (temp_ld),
        .rh_ld_o    (rh_ld),
        .done_o     (done)
    );

    // ==================================================================
    // read view; reset bit always reads back as zero once taken
    always_comb begin
        cfg_word = 16'h0000;
        cfg_word[hsr_pkg::CFG_HEAT_BIT] = s_r.cfg.heat;
        cfg_word[hsr_pkg::CFG_MODE_BIT] = s_r.cfg.mode;
        cfg_word[hsr_pkg::CFG_SUP_BIT]  = s_r.sup;
        cfg_word[hsr_pkg::CFG_TEMP_RESOLUTION_SEL_BIT] = s_r.cfg.temp_resolution_sel;
        cfg_word[hsr_pkg::CFG_RH_RESOLUTION_SEL_LO+:2] = s_r.cfg.rh_resolution_sel;
        unique case (s_r.ptr)
            hsr_pkg::PTR_TEMP:   rword = s_r.temp;
            hsr_pkg::PTR_HUM:    rword = s_r.rh;
            hsr_pkg::PTR_CFG:    rword = cfg_word;
            hsr_pkg::PTR_SN_HI:  rword = UNIQUE_PART_NUMBER[39:24];
            hsr_pkg::PTR_SN_MID: rword = UNIQUE_PART_NUMBER[23:8];
            hsr_pkg::PTR_SN_LO:  rword = {UNIQUE_PART_NUMBER[7:0],
                                          8'h00};
            default:             rword = 16'h0000;
        endcase
    end

    assign ptr_result = (s_r.ptr == hsr_pkg::PTR_TEMP) ||
                        (s_r.ptr == hsr_pkg::PTR_HUM);
    assign ptr_known  = (link_i.wr_byte <= hsr_pkg::PTR_CFG) ||
                        ((link_i.wr_byte >= hsr_pkg::PTR_SN_HI) &&
                         (link_i.wr_byte <= hsr_pkg::PTR_SN_LO));
    assign wword      = {s_r.wbuf, link_i.wr_byte};

    // ==================================================================
    // next state
    always_comb begin
        logic swr;
        swr                 = 1'b0;
        s_nxt               = s_r;
        s_nxt.resp          = '0;
        s_nxt.resp.rd_byte  = s_r.resp.rd_byte;
        s_nxt.trig          = 1'b0;
        s_nxt.clr           = 1'b0;
        // supply flag is asynchronous to this clock
        s_nxt.sup_sync      = {s_r.sup_sync[0], supply_low_i};
        s_nxt.sup           = s_r.sup_sync[1];
        if (temp_ld) begin
            s_nxt.temp = {temp_code_i, 2'b00};
        end
        if (rh_ld) begin
            s_nxt.rh = {rh_code_i, 2'b00};
        end
        if (link_i.stop) begin
            s_nxt.st = hsr_pkg::HSR_IDLE;
        end else if (link_i.start) begin
            s_nxt.hi = 1'b1;
            if (link_i.rnw) begin
                // reading an unfinished result is refused
                s_nxt.st             = hsr_pkg::HSR_RD;
                s_nxt.resp.ack_valid = 1'b1;
                s_nxt.resp.ack       = !(busy && ptr_result);
            end else begin
                s_nxt.st = hsr_pkg::HSR_PTR;
            end
        end else if (link_i.wr_valid && s_r.st == hsr_pkg::HSR_PTR) begin
            s_nxt.ptr            = link_i.wr_byte;
            s_nxt.resp.ack_valid = 1'b1;
            s_nxt.resp.ack       = ptr_known;
            s_nxt.st             = hsr_pkg::HSR_WR;
            if (link_i.wr_byte <= hsr_pkg::PTR_HUM) begin
                s_nxt.trig   = 1'b1;
                s_nxt.drdy_n = 1'b1;
            end
        end else if (link_i.wr_valid && s_r.st == hsr_pkg::HSR_WR) begin
            s_nxt.resp.ack_valid = 1'b1;
            s_nxt.resp.ack       = (s_r.ptr == hsr_pkg::PTR_CFG);
            if (s_r.ptr == hsr_pkg::PTR_CFG) begin
                s_nxt.hi = !s_r.hi;
                if (s_r.hi) begin
                    s_nxt.wbuf = link_i.wr_byte;
                end else if (wword[hsr_pkg::CFG_RST_BIT]) begin
                    swr = 1'b1;
                end else begin
                    s_nxt.cfg.heat = wword[hsr_pkg::CFG_HEAT_BIT];
                    s_nxt.cfg.mode = wword[hsr_pkg::CFG_MODE_BIT];
                    s_nxt.cfg.temp_resolution_sel = wword[hsr_pkg::CFG_TEMP_RESOLUTION_SEL_BIT];
                    s_nxt.cfg.rh_resolution_sel = wword[hsr_pkg::CFG_RH_RESOLUTION_SEL_LO+:2];
                end
            end
        end else if (link_i.rd_req && s_r.st == hsr_pkg::HSR_RD) begin
            s_nxt.resp.rd_valid = 1'b1;
            s_nxt.resp.rd_byte  = s_r.hi ? rword[15:8] : rword[7:0];
            s_nxt.hi            = !s_r.hi;
            if (!s_r.hi && ptr_result) begin
                s_nxt.drdy_n = 1'b1;
            end
        end
        // a finished conversion beats a same-cycle read release
        if (done) begin
            s_nxt.drdy_n = 1'b0;
        end
        if (swr) begin
            s_nxt.ptr    = hsr_pkg::PTR_RESET;
            s_nxt.cfg    = '0;
            s_nxt.cfg.mode = 1'b1;
            s_nxt.temp   = hsr_pkg::RESULT_RESET;
            s_nxt.rh     = hsr_pkg::RESULT_RESET;
            s_nxt.drdy_n = 1'b1;
            s_nxt.clr    = 1'b1;
            s_nxt.trig   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r          <= '0;
            s_r.st       <= hsr_pkg::HSR_IDLE;
            s_r.ptr      <= hsr_pkg::PTR_RESET;
            s_r.cfg.mode <= 1'b1;
            s_r.temp     <= hsr_pkg::RESULT_RESET;
            s_r.rh       <= hsr_pkg::RESULT_RESET;
            s_r.drdy_n   <= 1'b1;
            s_r.hi       <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign resp_o              = s_r.resp;
    assign conversion_done_n_o = s_r.drdy_n;
    assign heater_en_o         = s_r.cfg.heat;

    // ==================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ptr_load;
        link_i.wr_valid && !link_i.start && !link_i.stop &&
            s_r.st == hsr_pkg::HSR_PTR |=> s_r.ptr == $past(link_i.wr_byte);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded from first byte");

    property p_reset_vals;
        disable iff (1'b0)
        rst_i |=> s_r.ptr == 8'h00 && cfg_word == 16'h1000 &&
            s_r.temp == 16'h0000 && s_r.rh == 16'h0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_ptr_reset;
        disable iff (1'b0)
        rst_i ##1 !rst_i |-> s_r.ptr == hsr_pkg::PTR_TEMP;
    endproperty
    a_ptr_reset: assert property (p_ptr_reset)
        else $error("pointer not at temperature after reset");

    property p_low_bits;
        s_r.temp[1:0] == 2'b00 && s_r.rh[1:0] == 2'b00;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("result low bits not zero");

    property p_rh_store;
        rh_ld && !s_nxt.clr |=> s_r.rh == {$past(rh_code_i), 2'b00};
    endproperty
    a_rh_store: assert property (p_rh_store)
        else $error("humidity code not stored as 14 bits");

    property p_soft_reset;
        link_i.wr_valid && !link_i.start && !link_i.stop &&
            s_r.st == hsr_pkg::HSR_WR && s_r.ptr == hsr_pkg::PTR_CFG &&
            !s_r.hi && s_r.wbuf[7]
            |=> cfg_word[15:12] == 4'h1 && s_r.ptr == 8'h00 ##1 !busy;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore defaults");

    property p_trigger;
        s_r.trig && !s_r.clr |=> busy ##0 conversion_done_n_o;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("pointer write did not start a measurement");

    property p_nack;
        link_i.wr_valid && !link_i.start && !link_i.stop &&
            s_r.st == hsr_pkg::HSR_WR && s_r.ptr != hsr_pkg::PTR_CFG
            |=> resp_o.ack_valid && !resp_o.ack;
    endproperty
    a_nack: assert property (p_nack)
        else $error("write to read-only register acknowledged");

    property p_sn_high;
        link_i.rd_req && !link_i.start && !link_i.stop &&
            s_r.st == hsr_pkg::HSR_RD && s_r.ptr == 8'hFB && s_r.hi
            |=> resp_o.rd_valid && resp_o.rd_byte == UNIQUE_PART_NUMBER[39:32];
    endproperty
    a_sn_high: assert property (p_sn_high)
        else $error("part number high byte wrong");

    property p_sn_low;
        s_r.ptr == 8'hFD |-> rword[6:0] == 7'h00 &&
            rword[15:8] == UNIQUE_PART_NUMBER[7:0];
    endproperty
    a_sn_low: assert property (p_sn_low)
        else $error("part number low register wrong");

    property p_supply;
        $rose(s_r.sup_sync[1]) |=> cfg_word[11];
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply flag not reported");

    c_trigger: cover property (s_r.trig ##[1:400] done);
    c_sn_read: cover property (resp_o.rd_valid && s_r.ptr == 8'hFC);
    c_soft_rst: cover property (s_r.clr);
endmodule

//--- verification/hsr_master.sv
// Purpose : bus master model that drives byte-level frames into the bank
// Assumes : one pulse per call, changed on the falling edge
// Notes   : a released data byte shows the inverse of the last one
`timescale 1ns/1ns
module hsr_master (
    // clock
    input  wire logic          clk_i,
    // frame link towards the bank
    output hsr_pkg::hsr_link_s link_o
);
    // ==================================================================
    // pulse driver
    // callers load the pointer before reads, except right after a reset, and keep reserved fields zero
    // scaling codes to degrees and percent is left to the reader's software
    initial begin
        link_o = '{1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0};
    end

    // kind: 0 write start, 1 read start, 2 byte, 3 read request, 4 stop
    task automatic pulse(input int k, input logic [7:0] b);
        @(negedge clk_i);
        link_o = '{(k < 2), (k == 1), (k == 2), b, (k == 3), (k == 4)};
        @(negedge clk_i);
        // stale byte inverted so a late sample never looks valid
        link_o = '{1'b0, 1'b0, 1'b0, ~b, 1'b0, 1'b0};
    endtask
endmodule

//--- verification/hsr_regbank_bench.sv
// Purpose : self-checking bench of the sensor register bank
// Assumes : answers come one cycle after the taking edge
// Notes   : conversion time is checked with a small window only
`timescale 1ns/1ns
module hsr_regbank_bench;
    // ==================================================================
    // stimulus tables
    localparam logic [39:0] PART_NUM = 40'h5A3C96E1B7; // arbitrary value
    localparam logic [15:0] CFG_T [6] = '{16'h0000, 16'h0400, 16'h0000,
                                          16'h0100, 16'h0200, 16'h1600};
    localparam logic [7:0]  PTR_T [6] = '{8'h00, 8'h00, 8'h01,
                                          8'h01, 8'h01, 8'h00};
    localparam int CYC [6] = '{hsr_pkg::CONV_14_CYC, hsr_pkg::CONV_11_CYC,
        hsr_pkg::CONV_14_CYC, hsr_pkg::CONV_11_CYC, hsr_pkg::CONV_8_CYC,
        hsr_pkg::CONV_11_CYC + hsr_pkg::CONV_8_CYC};

    logic               clk_i;
    logic               rst_i;
    logic               supply_low_i;
    logic [13:0]        temp_code_i;
    logic [13:0]        rh_code_i;
    hsr_pkg::hsr_link_s link;
    hsr_pkg::hsr_resp_s resp;
    logic               conv_done_n;
    logic               heat;
    logic               ack_q [$];
    logic [7:0]         rd_q [$];
    logic [15:0]        tw;
    logic [15:0]        hw;
    int                 bad_count;
    int                 n_checks;
    int                 cnt;

    hsr_master u_hsr_master (.clk_i(clk_i), .link_o(link));

    hsr_regbank #(.UNIQUE_PART_NUMBER(PART_NUM)) u_hsr_regbank (
        .clk_i(clk_i), .rst_i(rst_i), .link_i(link), .resp_o(resp),
        .temp_code_i(temp_code_i), .rh_code_i(rh_code_i),
        .supply_low_i(supply_low_i), .conversion_done_n_o(conv_done_n),
        .heater_en_o(heat));

    // ==================================================================
    // compare and report
    task automatic chk_ack(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t ack %b expected %b", $time, g, e);
        end
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t read %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_lvl(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t level %b expected %b", $time, g, e);
        end
    endtask

    task automatic results();
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // an answer with no note left compares against unknown and fails
    // sampled mid-cycle, where the registered answer has settled
    always @(negedge clk_i) begin
        if (resp.ack_valid === 1'b1) begin
            chk_ack(resp.ack, ack_q.size() ? ack_q.pop_front() : 1'bx);
        end
        if (resp.rd_valid === 1'b1) begin
            chk_byte(resp.rd_byte,
                     rd_q.size() ? rd_q.pop_front() : 8'hXX);
        end
    end

    // ==================================================================
    // frame tasks
    task automatic wr(input logic [7:0] p, input int n, input logic [15:0] w,
                      input logic ea, input logic ed);
        u_hsr_master.pulse(0, 8'h00);
        ack_q.push_back(ea);
        u_hsr_master.pulse(2, p);
        for (int k = 0; k < n; k++) begin
            ack_q.push_back(ed);
            u_hsr_master.pulse(2, (k == 0) ? w[15:8] : w[7:0]);
        end
        u_hsr_master.pulse(4, 8'h00);
    endtask

    task automatic rd(input logic ea, input logic [15:0] w);
        ack_q.push_back(ea);
        u_hsr_master.pulse(1, 8'h00);
        if (ea) begin
            rd_q.push_back(w[15:8]);
            u_hsr_master.pulse(3, 8'h00);
            rd_q.push_back(w[7:0]);
            u_hsr_master.pulse(3, 8'h00);
        end
        u_hsr_master.pulse(4, 8'h00);
    endtask

    // ==================================================================
    // clock and main sequence
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        supply_low_i = 1'b0;
        temp_code_i = 14'h0000;
        rh_code_i = 14'h0000;
        bad_count = 0;
        n_checks = 0;
        void'($urandom(32'hA45391D2));
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        rd(1'b1, hsr_pkg::RESULT_RESET);
        wr(hsr_pkg::PTR_CFG, 0, 16'h0000, 1'b1, 1'b1);
        rd(1'b1, hsr_pkg::CFG_RESET);
        supply_low_i = 1'b1;
        wr(hsr_pkg::PTR_CFG, 2, 16'h3000, 1'b1, 1'b1);
        chk_lvl(heat, 1'b1);
        rd(1'b1, 16'h3800);
        supply_low_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            temp_code_i = 14'($urandom);
            rh_code_i = 14'($urandom);
            tw = {temp_code_i, 2'b00};
            hw = {rh_code_i, 2'b00};
            wr(hsr_pkg::PTR_CFG, 2, CFG_T[i], 1'b1, 1'b1);
            // only the last pass runs a combined acquisition, once per run
            wr(PTR_T[i], 0, 16'h0000, 1'b1, 1'b1);
            rd(1'b0, 16'h0000);
            cnt = 0;
            while (conv_done_n !== 1'b0 && cnt < 1000) begin
                @(negedge clk_i);
                cnt++;
            end
            if (cnt == 1000) begin
                bad_count++;
                results();
            end
            chk_lvl(cnt >= CYC[i] - 8 && cnt <= CYC[i] + 4, 1'b1);
            rd(1'b1, (PTR_T[i] == 8'h01) ? hw : tw);
            chk_lvl(conv_done_n, 1'b1);
        end
        wr(hsr_pkg::PTR_SN_HI, 0, 16'h0000, 1'b1, 1'b1);
        rd(1'b1, PART_NUM[39:24]);
        wr(hsr_pkg::PTR_SN_MID, 0, 16'h0000, 1'b1, 1'b1);
        rd(1'b1, PART_NUM[23:8]);
        wr(hsr_pkg::PTR_SN_LO, 0, 16'h0000, 1'b1, 1'b1);
        rd(1'b1, {PART_NUM[7:0], 8'h00});
        wr(hsr_pkg::PTR_SN_HI, 2, 16'hFFFF, 1'b1, 1'b0);
        rd(1'b1, PART_NUM[39:24]);
        wr(8'hFE, 0, 16'h0000, 1'b0, 1'b0);
        // soft reset with heater asked for: reset must win
        wr(hsr_pkg::PTR_CFG, 2, 16'hA000, 1'b1, 1'b1);
        chk_lvl(heat, 1'b0);
        rd(1'b1, hsr_pkg::RESULT_RESET);
        wr(hsr_pkg::PTR_CFG, 0, 16'h0000, 1'b1, 1'b1);
        rd(1'b1, hsr_pkg::CFG_RESET);
        repeat (3) @(negedge clk_i);
        // every noted answer must have been seen
        chk_lvl(ack_q.size() == 0 && rd_q.size() == 0, 1'b1);
        results();
    end
endmodule
